//--- design/rors_top.v
// Refresh sequencer with clock source selection and channel code store
`timescale 1ns/100ps
`include "rors_map.vh"
module rors_top (
    input wire clk_in,                  // System clock, 40 MHz
    input wire rst_in,                  // Synchronous reset, active high
    input wire clock_mode_in,           // Low internal, high external
    input wire refresh_clock_pin_in,    // Pin level from outside
    output reg refresh_clock_pin_out,   // Pin drive value
    output reg refresh_clock_pin_oe_n_out, // Low while driving the pin
    input wire serial_select_n_in,      // Serial select, active low
    input wire serial_clk_in,           // Serial shift clock
    input wire serial_data_in,          // Serial data, MSB first
    input wire thermal_hot_in,          // Die reached shutdown level
    input wire thermal_cool_in,         // Die dropped to recovery level
    output reg [4:0] refresh_channel_out, // Channel being refreshed
    output reg hold_switch_closed_out,  // Refresh switches closed
    output reg [9:0] converter_code_out, // Code presented to converter
    output reg enabled_out              // Part enabled, not shut down
);
    // ****************************************
    // Declarations
    // ****************************************
    localparam ST_LOW = 2'b01;  // Refresh clock low phase
    localparam ST_HIGH = 2'b10; // Refresh clock high phase

    wire int_osc;               // Internal oscillator
    reg [1:0] mode_s_r;         // Mode synchroniser
    reg [1:0] pin_s_r;          // Pin clock synchroniser
    reg [1:0] sel_s_r;          // Select synchroniser
    reg [1:0] sck_s_r;          // Serial clock synchroniser
    reg [1:0] sdi_s_r;          // Serial data synchroniser
    reg [1:0] hot_s_r;          // Hot flag synchroniser
    reg [1:0] cool_s_r;         // Cool flag synchroniser
    reg use_ext_r;              // Active clock source
    reg rclk_r;                 // Selected refresh clock
    reg pin_d_r;                // Previous synced pin level
    reg int_d_r;                // Previous internal oscillator level
    reg [2:0] rel_r;            // Recent pin release history
    reg [1:0] state_r;          // Refresh phase state
    reg [1:0] state_nxt;        // Next phase
    reg sck_d_r;                // Delayed serial clock
    reg sel_d_r;                // Delayed select
    reg [15:0] shift_r;         // Serial shift register
    reg [4:0] bits_r;           // Bits shifted in frame
    reg [9:0] target_r [0:17];  // Loaded channel codes
    reg [10:0] held_r [0:17];   // Code now held per channel
    reg [4:0] ptr_r;            // Refresh pointer
    reg [10:0] step_v;          // Stepped code for this visit
    integer i;                  // Loop index

    // Step one held code toward its target by at most the step limit
    function [10:0] rors_step;
        input [10:0] held;
        input [9:0] tgt;
        reg [10:0] t;
        begin
            t = {1'b0, tgt};
            if (t > held + `RORS_STEP_MAX)
                rors_step = held + `RORS_STEP_MAX;
            else if (held > t + `RORS_STEP_MAX)
                rors_step = held - `RORS_STEP_MAX;
            else
                rors_step = t;
        end
    endfunction

    // ****************************************
    // Internal oscillator
    // ****************************************
    rors_osc u_osc (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .osc_out(int_osc)
    );

    // ****************************************
    // Input synchronisers
    // ****************************************
    // Two flops on every input from outside the clock domain
    always @(posedge clk_in) begin
        if (rst_in) begin
            mode_s_r <= 2'b00;
            pin_s_r <= 2'b11;
            sel_s_r <= 2'b11;
            sck_s_r <= 2'b00;
            sdi_s_r <= 2'b00;
            hot_s_r <= 2'b00;
            cool_s_r <= 2'b00;
        end else begin
            mode_s_r <= {mode_s_r[0], clock_mode_in};
            pin_s_r <= {pin_s_r[0], refresh_clock_pin_in};
            sel_s_r <= {sel_s_r[0], serial_select_n_in};
            sck_s_r <= {sck_s_r[0], serial_clk_in};
            sdi_s_r <= {sdi_s_r[0], serial_data_in};
            hot_s_r <= {hot_s_r[0], thermal_hot_in};
            cool_s_r <= {cool_s_r[0], thermal_cool_in};
        end
    end

    // ****************************************
    // Clock source selection
    // ****************************************
    // Source changes on the new source's rising edge while the old one is high,
    // so the high phase in progress is stretched, never cut short
    always @(posedge clk_in) begin
        if (rst_in) begin
            use_ext_r <= 1'b0;
            rclk_r <= 1'b1;
            pin_d_r <= 1'b1;
            int_d_r <= 1'b1;
            rel_r <= 3'b111;
        end else begin
            pin_d_r <= pin_s_r[1];
            int_d_r <= int_osc;
            rel_r <= {rel_r[1:0], refresh_clock_pin_oe_n_out};
            // Pin released long enough that the synchroniser shows the far source
            if (mode_s_r[1] && !use_ext_r && (&rel_r) && int_osc && pin_s_r[1] && !pin_d_r)
                use_ext_r <= 1'b1;
            else if (!mode_s_r[1] && use_ext_r && pin_s_r[1] && int_osc && !int_d_r)
                use_ext_r <= 1'b0;
            rclk_r <= use_ext_r ? pin_s_r[1] : int_osc;
        end
    end

    // Pin drive: released at reset, driven only in internal mode
    always @(posedge clk_in) begin
        if (rst_in) begin
            refresh_clock_pin_out <= 1'b1;
            refresh_clock_pin_oe_n_out <= 1'b1;
        end else begin
            refresh_clock_pin_out <= int_osc;
            // Release as soon as external is asked for; drive again once switched back
            refresh_clock_pin_oe_n_out <= mode_s_r[1] | use_ext_r;
        end
    end

    // ****************************************
    // Serial load of channel codes
    // ****************************************
    // Shift on serial clock rising edge; commit on select release
    always @(posedge clk_in) begin
        if (rst_in) begin
            sck_d_r <= 1'b0;
            sel_d_r <= 1'b1;
            shift_r <= 16'h0000;
            bits_r <= 5'h00;
            for (i = 0; i < `RORS_NUM_CH; i = i + 1) begin
                target_r[i] <= 10'h000;
            end
        end else begin
            sck_d_r <= sck_s_r[1];
            sel_d_r <= sel_s_r[1];
            if (sel_s_r[1]) begin
                bits_r <= 5'h00; // Frame idle
            end else if (sck_s_r[1] && !sck_d_r) begin
                shift_r <= {shift_r[14:0], sdi_s_r[1]};
                if (bits_r != 5'h1f)
                    bits_r <= bits_r + 5'h01;
            end
            // Complete word and valid address updates one code
            if (sel_s_r[1] && !sel_d_r && bits_r >= `RORS_WORD_BITS &&
                shift_r[`RORS_ADDR_MSB:`RORS_ADDR_LSB] <= `RORS_LAST_CH) begin
                target_r[shift_r[`RORS_ADDR_MSB:`RORS_ADDR_LSB]] <=
                    shift_r[`RORS_CODE_MSB:0];
            end
        end
    end

    // ****************************************
    // Refresh phase machine
    // ****************************************
    // Next phase follows the selected refresh clock
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_LOW: begin
                if (rclk_r)
                    state_nxt = ST_HIGH;
            end
            ST_HIGH: begin
                if (!rclk_r)
                    state_nxt = ST_LOW;
            end
            default: begin
                state_nxt = ST_HIGH;
            end
        endcase
    end

    // Current held code of the pointed channel, stepped toward target
    always @* begin
        step_v = rors_step(held_r[ptr_r], target_r[ptr_r]);
    end

    // Falling edge refreshes pointer channel; rising edge opens and advances
    always @(posedge clk_in) begin
        if (rst_in) begin
            state_r <= ST_HIGH;
            ptr_r <= 5'h00;
            hold_switch_closed_out <= 1'b0;
            refresh_channel_out <= 5'h00;
            converter_code_out <= 10'h000;
            for (i = 0; i < `RORS_NUM_CH; i = i + 1) begin
                held_r[i] <= 11'h000;
            end
        end else begin
            state_r <= state_nxt;
            if (state_r == ST_HIGH && state_nxt == ST_LOW && enabled_out) begin
                hold_switch_closed_out <= 1'b1;
                refresh_channel_out <= ptr_r;
                held_r[ptr_r] <= step_v;
                // Held code below full scale maps as low ref + code/1024 span
                converter_code_out <= step_v[9:0];
            end else if (state_r == ST_LOW && state_nxt == ST_HIGH) begin
                hold_switch_closed_out <= 1'b0;
                if (ptr_r == `RORS_LAST_CH)
                    ptr_r <= 5'h00;
                else
                    ptr_r <= ptr_r + 5'h01;
            end else if (!enabled_out) begin
                hold_switch_closed_out <= 1'b0;
            end
        end
    end

    // ****************************************
    // Thermal shutdown with hysteresis
    // ****************************************
    always @(posedge clk_in) begin
        if (rst_in) begin
            enabled_out <= 1'b1;
        end else if (hot_s_r[1]) begin
            enabled_out <= 1'b0;
        end else if (cool_s_r[1]) begin
            enabled_out <= 1'b1;
        end
    end
endmodule

//--- common/rors_map.vh
// Constants for the reference output refresh sequencer
`ifndef RORS_MAP_VH
`define RORS_MAP_VH
// ****************************************
// Channel and word layout
// ****************************************
`define RORS_NUM_CH 18
`define RORS_LAST_CH 5'h11
`define RORS_WORD_BITS 16
`define RORS_ADDR_MSB 14
`define RORS_ADDR_LSB 10
`define RORS_CODE_MSB 9
`define RORS_CODE_FULL 11'h400
// ****************************************
// Timing
// ****************************************
`define RORS_CLK_HZ 40000000
`define RORS_OSC_HZ 21000
// Half period of internal oscillator in clk cycles, rounded down
`define RORS_OSC_HALF ((`RORS_CLK_HZ / `RORS_OSC_HZ) / 2)
// Largest code step per visit; full span assumed 16 V, so 2 V = 128 codes
`define RORS_STEP_MAX 11'h080
`endif

//--- design/rors_osc.v
// Internal refresh oscillator, divided from the system clock
`timescale 1ns/100ps
`include "rors_map.vh"
module rors_osc (
    input wire clk_in,   // System clock
    input wire rst_in,   // Synchronous reset, active high
    output reg osc_out   // Internal refresh clock, about 21 kHz
);
    // ****************************************
    // Divider
    // ****************************************
    reg [9:0] cnt_r; // Half period counter

    // Toggle the output every half period
    always @(posedge clk_in) begin
        if (rst_in) begin
            cnt_r <= 10'h000;
            osc_out <= 1'b1;
        end else if (cnt_r == (`RORS_OSC_HALF - 1)) begin
            cnt_r <= 10'h000;
            osc_out <= ~osc_out;
        end else begin
            cnt_r <= cnt_r + 10'h001;
        end
    end
endmodule

//--- verification/rors_checker.sv
// Port checker for the refresh sequencer
`timescale 1ns/100ps
module rors_checker (
    input wire clk_in, // System clock
    input wire rst_in, // Reset, active high
    input wire refresh_clock_pin_in, // Pin level
    input wire refresh_clock_pin_oe_n_out, // High while pin released
    input wire [4:0] refresh_channel_out, // Channel refreshed
    input wire hold_switch_closed_out, // Switches closed
    input wire [9:0] converter_code_out, // Code at converter
    input wire enabled_out // Not shut down
);
    wire [4:0] ch = refresh_channel_out; // Short aliases
    wire sw = hold_switch_closed_out;
    wire pin = refresh_clock_pin_in;
    wire ext = refresh_clock_pin_oe_n_out;
    logic seen_r = 1'b0; // A refresh seen since reset or shutdown
    logic [11:0] rel_cnt_r = 12'h000; // Cycles the pin has stayed released
    // Helper state: order is only judged between unbroken refreshes
    always @(posedge clk_in) begin
        if (rst_in || !enabled_out) seen_r <= 1'b0;
        else if (sw) seen_r <= 1'b1;
        if (rst_in || !ext) rel_cnt_r <= 12'h000;
        else if (rel_cnt_r != 12'hfff) rel_cnt_r <= rel_cnt_r + 12'h001;
    end
    wire ext_ok = (rel_cnt_r == 12'hfff); // External source surely in charge
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // ****************************************
    // Assertions
    // ****************************************
    a_reset_state: assert property ($fell(rst_in) |-> ext && !sw && ch == 5'h00)
        else $error("state after reset wrong");
    a_chan_range: assert property (ch <= 5'h11)
        else $error("channel beyond last");
    a_next_chan: assert property ($rose(sw) && seen_r |->
        ch == (($past(ch) == 5'h11) ? 5'h00 : $past(ch) + 5'h01))
        else $error("channel order broken");
    a_chan_stands: assert property (!$rose(sw) |-> $stable(ch) && $stable(converter_code_out))
        else $error("channel or code moved between refreshes");
    a_fall_connect: assert property ($fell(pin) && ext_ok && enabled_out |-> ##[2:5] sw)
        else $error("falling edge did not close switches");
    a_rise_open: assert property ($rose(pin) && ext_ok |-> ##[2:5] !sw)
        else $error("rising edge did not open switches");
    a_no_glitch: assert property ($rose(sw) |-> sw [*8])
        else $error("short refresh phase");
    a_shutdown_open: assert property (!enabled_out && !$past(enabled_out) |-> !sw)
        else $error("refresh while shut down");
    c_refresh: cover property ($rose(sw));
    c_last_chan: cover property ($rose(sw) && ch == 5'h11);
    c_shutdown: cover property (!enabled_out);
endmodule
bind rors_top rors_checker u_chk (.clk_in(clk_in), .rst_in(rst_in),
    .refresh_clock_pin_in(refresh_clock_pin_in),
    .refresh_clock_pin_oe_n_out(refresh_clock_pin_oe_n_out),
    .refresh_channel_out(refresh_channel_out), .hold_switch_closed_out(hold_switch_closed_out),
    .converter_code_out(converter_code_out), .enabled_out(enabled_out));

//--- verification/rors_ext_src.sv
// External refresh clock source model
`timescale 1ns/100ps
module rors_ext_src #(parameter int HALF = 300) (
    input wire logic clk_in, // System clock
    input wire logic run_in, // Run the clock
    output logic pin_out // Clock level, idle high
);
    int cnt = 0; // Phase counter
    initial pin_out = 1'b1;
    // 600 clk period: 66.7 kHz, 7.5 us phases, 50 % duty
    always @(negedge clk_in) begin
        if (!run_in) begin
            cnt <= 0;
            pin_out <= 1'b1;
        end else if (cnt == HALF - 1) begin
            cnt <= 0;
            // Edges sit on a fixed count, so rising edges keep clear of load steps
            pin_out <= !pin_out;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule

//--- verification/reference_output_refresh_sequencer_tb_top.sv
// Self-checking bench for the refresh sequencer
`timescale 1ns/100ps
`include "rors_map.vh"
module reference_output_refresh_sequencer_tb_top;
    logic clk_in = 1'b0, rst_in = 1'b1, mode = 1'b0, run = 1'b0, hot = 1'b0, cool = 1'b1;
    logic sel_n = 1'b1, sclk = 1'b0, sdat = 1'b0, pin_drv, oe_n, sw, en, ext_pin;
    logic [4:0] ch;
    logic [9:0] code;
    wire pin_lvl = oe_n ? ext_pin : pin_drv; // Resolved pin
    int failures = 0, cmp_count = 0;
    rors_top DUT (.clk_in(clk_in), .rst_in(rst_in), .clock_mode_in(mode),
        .refresh_clock_pin_in(pin_lvl), .refresh_clock_pin_out(pin_drv),
        .refresh_clock_pin_oe_n_out(oe_n), .serial_select_n_in(sel_n), .serial_clk_in(sclk),
        .serial_data_in(sdat), .thermal_hot_in(hot), .thermal_cool_in(cool),
        .refresh_channel_out(ch), .hold_switch_closed_out(sw), .converter_code_out(code),
        .enabled_out(en));
    rors_ext_src #(.HALF(300)) u_src (.clk_in(clk_in), .run_in(run), .pin_out(ext_pin));
    initial forever #12.5 clk_in = ~clk_in;
    // ****************************************
    // Helpers
    // ****************************************
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict;
        if (failures == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Waits for the next closing of the switches
    task automatic wait_visit(output logic [4:0] c, output logic [9:0] d, output int n);
        n = 0;
        while (sw === 1'b1 && n < 3000) begin @(negedge clk_in); n++; end
        while (sw !== 1'b1 && n < 3000) begin @(negedge clk_in); n++; end
        check("refresh wait", 1, n < 3000);
        c = ch;
        d = code;
    endtask
    task automatic visit_ch(input logic [4:0] k, output logic [9:0] d);
        logic [4:0] c;
        int n, v;
        v = 0;
        do begin wait_visit(c, d, n); v++; end while (c !== k && v < 20);
        check("visits to channel", 1, v <= 18);
    endtask
    task automatic write_word(input logic [15:0] w);
        @(negedge clk_in) sel_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            repeat (4) @(negedge clk_in) sdat = w[i];
            repeat (4) @(negedge clk_in) sclk = 1'b1;
            repeat (4) @(negedge clk_in) sclk = 1'b0;
        end
        repeat (4) @(negedge clk_in) sel_n = 1'b1;
        repeat (8) @(negedge clk_in);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_internal;
        logic [4:0] c;
        logic [9:0] d;
        logic p;
        int n;
        n = 0;
        while (oe_n !== 1'b0 && n < 4000) begin @(negedge clk_in); n++; end
        check("pin driven", 0, oe_n);
        for (int k = 0; k < 2; k++) begin
            p = pin_drv;
            n = 0;
            while (pin_drv === p && n < 3000) begin @(negedge clk_in); n++; end
        end
        check("osc half period", `RORS_OSC_HALF, n);
        wait_visit(c, d, n);
        check("pin low at refresh", 0, pin_drv);
    endtask
    task automatic t_external;
        logic [4:0] c, p;
        logic [9:0] d;
        int n;
        mode = 1'b1;
        run = 1'b1;
        n = 0;
        while (oe_n !== 1'b1 && n < 3000) begin @(negedge clk_in); n++; end
        check("pin released", 1, oe_n);
        wait_visit(p, d, n);
        for (int k = 0; k < 19; k++) begin
            wait_visit(c, d, n);
            check("next channel", (p == 5'h11) ? 5'h00 : p + 5'h01, c);
            check("refresh spacing", 600, n);
            p = c;
        end
    endtask
    task automatic t_update;
        logic [9:0] d;
        write_word({1'b0, 5'h05, 10'h05a});
        visit_ch(5'h05, d);
        check("channel 5 code", 10'h05a, d);
        write_word({1'b0, 5'h11, 10'h07f});
        visit_ch(5'h11, d);
        check("channel 17 code", 10'h07f, d);
        write_word({1'b0, 5'h02, 10'h3ff});
        visit_ch(5'h02, d);
        check("first step", `RORS_STEP_MAX, d);
        visit_ch(5'h02, d);
        check("second step", 2 * `RORS_STEP_MAX, d);
    endtask
    task automatic t_thermal;
        // Let the closure in progress pass its minimum length first
        repeat (16) @(negedge clk_in);
        @(negedge clk_in) {hot, cool} = 2'b10;
        repeat (1300) @(negedge clk_in);
        check("hot disables", 0, en);
        check("switches open", 0, sw);
        hot = 1'b0;
        repeat (20) @(negedge clk_in);
        check("hysteresis keeps off", 0, en);
        cool = 1'b1;
        repeat (20) @(negedge clk_in);
        check("cool enables", 1, en);
    endtask
    initial begin
        repeat (100000) @(posedge clk_in);
        failures++;
        print_verdict;
    end
    initial begin
        repeat (4) @(negedge clk_in);
        check("reset pin release", 1, oe_n);
        check("reset channel", 0, ch);
        check("reset switches", 0, sw);
        rst_in = 1'b0;
        repeat (2) @(negedge clk_in);
        t_internal;
        t_external;
        t_update;
        t_thermal;
        print_verdict;
    end
endmodule
